// ### hw/pin_select.sv
// remappable output pin selection with mapping write lock
`timescale 1ns/100ps
module pin_select
   import pin_select_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire map_write_t map_wr_in,
   input wire cfg_write_t cfg_wr_in,
   input wire logic [31:0] dev_cfg3_in,
   input wire logic [NUM_PERIPH-1:0] periph_out_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS*SEL_W-1:0] pin_output_select_out,
   output logic [NUM_INPUTS*SEL_W-1:0] input_select_out,
   output logic pin_map_lock_out,
   output logic [31:0] config_control_out
);
   // ============================================================
   // lock
   logic lock;
   lock_ctrl lock_ctrl_inst
   (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .cfg_wr_in(cfg_wr_in),
      .dev_cfg3_in(dev_cfg3_in),
      .lock_out(lock)
   );
   assign pin_map_lock_out = lock;

   // ============================================================
   // mapping registers
   logic [SEL_W-1:0] out_sel_ff [NUM_PINS];
   logic [SEL_W-1:0] in_sel_ff [NUM_INPUTS];
   // write is acknowledged by the caller regardless; data simply dropped when locked
   wire logic wr_ok = map_wr_in.en && !lock;                              // [R3] [R4]
   wire logic out_wr = wr_ok && !map_wr_in.is_input;
   wire logic in_wr = wr_ok && map_wr_in.is_input;

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         for (int i = 0; i < NUM_PINS; i++)
            out_sel_ff[i] <= SEL_NULL;                                  // [R2]
         for (int i = 0; i < NUM_INPUTS; i++)
            in_sel_ff[i] <= SEL_NULL;
      end
      else
      begin
         if (out_wr)
            out_sel_ff[map_wr_in.idx] <= map_wr_in.data;                // [R1]
         if (in_wr)
            in_sel_ff[map_wr_in.idx] <= map_wr_in.data;                 // [R3]
      end
   end

   // ============================================================
   // output routing, registered so pins come from flip-flops
   logic [NUM_PINS-1:0] pin_ff;
   logic [NUM_PINS-1:0] nxt_pin;
   always_comb
   begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
         // code zero routes nothing: the pin stays low
         nxt_pin[i] = (out_sel_ff[i] != SEL_NULL) && periph_out_in[out_sel_ff[i]]; // [R1] [R2]
         pin_output_select_out[i*SEL_W +: SEL_W] = out_sel_ff[i];
      end
      for (int i = 0; i < NUM_INPUTS; i++)
         input_select_out[i*SEL_W +: SEL_W] = in_sel_ff[i];
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         pin_ff <= '0;
      else
         pin_ff <= nxt_pin;
   end
   assign pin_out = pin_ff;

   always_comb
   begin
      config_control_out = 32'h00000000;
      config_control_out[LOCK_BIT] = lock;                               // [R4]
   end

   a_locked_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R3]
      (map_wr_in.en && lock && !map_wr_in.is_input) |=> $stable(pin_output_select_out))
      else $error("locked output map write took effect");
   a_locked_in_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R3]
      (map_wr_in.en && lock && map_wr_in.is_input) |=> $stable(input_select_out))
      else $error("locked input map write took effect");
   a_write_lands: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R1]
      (map_wr_in.en && !lock && !map_wr_in.is_input) |=>
      pin_output_select_out[$past(map_wr_in.idx)*SEL_W +: SEL_W] == $past(map_wr_in.data))
      else $error("unlocked map write lost");
   a_null_quiet: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R2]
      (pin_output_select_out[SEL_W-1:0] == SEL_NULL) |=> !pin_out[0])
      else $error("null-selected pin driven");
   a_in_write_lands: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R1]
      (map_wr_in.en && !lock && map_wr_in.is_input) |=>
      input_select_out[$past(map_wr_in.idx)*SEL_W +: SEL_W] == $past(map_wr_in.data))
      else $error("unlocked input map write lost");

   // ============================================================
   // per-pin routing checks
   // every pin is watched, not only pin zero, so a decode slip on one index shows up
   for (genvar g = 0; g < NUM_PINS; g++)
   begin : g_pin_chk
      a_pin_routes: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R1]
         (pin_output_select_out[g*SEL_W +: SEL_W] != SEL_NULL) |=>
         (pin_out[g] == $past(periph_out_in[pin_output_select_out[g*SEL_W +: SEL_W]])))
         else $error("selected peripheral not routed to pin");
      a_pin_null: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R2]
         (pin_output_select_out[g*SEL_W +: SEL_W] == SEL_NULL) |=> !pin_out[g])
         else $error("null-selected pin driven");
   end
endmodule : pin_select

// ### inc/pin_select_pkg.sv
// constants and carrier types for the remappable output pin select block
// ============================================================
// What this block does
// R1 - each remappable pin has its own 4-bit selection field that picks which peripheral output drives it.
// R2 - a selection value of zero is the null output, and every field resets to zero so no pin is driven.
// R3 - while the lock is set, mapping writes complete normally but leave the stored contents unchanged.
// R4 - the lock is bit 13 of the configuration control word; one blocks mapping writes, zero allows them.
// R5 - the lock bit changes only after software has performed the unlock sequence.
// R6 - with the one-way option set, a lock that has been set cannot be cleared by the unlock procedure.
// R7 - in one-way mode only a device reset clears the lock and re-enables remapping.
// R8 - an unprogrammed configuration word reads as the one-way option enabled.
// R9 - the lock returns to cleared on device reset.
package pin_select_pkg;
   localparam int NUM_PINS = 8;
   localparam int SEL_W = 4;
   localparam int NUM_PERIPH = 16;
   localparam int PIN_IDX_W = 3;
   localparam int NUM_INPUTS = 8;
   localparam int IN_IDX_W = 3;
   localparam int LOCK_BIT = 13;
   localparam int ONE_WAY_BIT = 29;
   localparam logic [SEL_W-1:0] SEL_NULL = 4'h0;
   localparam logic LOCK_RESET = 1'b0;
   localparam logic [31:0] CFG3_UNPROGRAMMED = 32'hFFFFFFFF;

   typedef struct packed
   {
      logic en;
      logic is_input;
      logic [PIN_IDX_W-1:0] idx;
      logic [SEL_W-1:0] data;
   } map_write_t;

   typedef struct packed
   {
      logic en;
      logic unlocked;
      logic [31:0] data;
   } cfg_write_t;
endpackage : pin_select_pkg

// ### hw/lock_ctrl.sv
// lock state for the pin mapping registers
`timescale 1ns/100ps
module lock_ctrl
   import pin_select_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire cfg_write_t cfg_wr_in,
   input wire logic [31:0] dev_cfg3_in,
   output logic lock_out
);
   typedef enum logic [1:0] {LK_OPEN = 2'b00, LK_SET = 2'b01} lock_state_t;
   lock_state_t state_ff;
   lock_state_t nxt_state;
   wire logic one_way = dev_cfg3_in[ONE_WAY_BIT];                       // [R6] [R8]
   wire logic req_lock = cfg_wr_in.data[LOCK_BIT];                       // [R4]
   wire logic accept = cfg_wr_in.en && cfg_wr_in.unlocked;               // [R5]

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         LK_OPEN:
         begin
            if (accept && req_lock)
               nxt_state = LK_SET;
         end
         LK_SET:
         begin
            // one-way: only reset leaves this state
            if (accept && !req_lock && !one_way)                       // [R6] [R7]
               nxt_state = LK_OPEN;
         end
         default:
            nxt_state = LK_OPEN;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         state_ff <= LK_OPEN;                                            // [R9]
      else
         state_ff <= nxt_state;
   end

   assign lock_out = (state_ff == LK_SET);

   a_one_way_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R7]
      (lock_out && one_way) |=> lock_out)
      else $error("one-way lock was cleared");
   a_lock_needs_key: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R5]
      !$past(accept) |-> $stable(lock_out))
      else $error("lock changed without unlock sequence");
   a_lock_follows: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R4]
      (accept && req_lock) |=> lock_out)
      else $error("lock not set on accepted write");
   a_lock_clears: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R6]
      (lock_out && accept && !req_lock && !one_way) |=> !lock_out)
      else $error("lock not cleared when allowed");
endmodule : lock_ctrl

// ### testbench/pin_select_bench.sv
// self-checking bench for the remappable output pin select block
`timescale 1ns/100ps
module pin_select_bench
   import pin_select_pkg::*;
;
   logic clk_in;
   logic rst_b_in;
   map_write_t map_wr_in;
   cfg_write_t cfg_wr_in;
   logic [31:0] dev_cfg3_in;
   logic [NUM_PERIPH-1:0] periph_out_in;
   logic [NUM_PINS-1:0] pin_out;
   logic [NUM_PINS*SEL_W-1:0] sel_out;
   logic [NUM_INPUTS*SEL_W-1:0] in_sel;
   logic lock;
   logic [31:0] cfg_out;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;

   pin_select pin_select_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .map_wr_in(map_wr_in),
      .cfg_wr_in(cfg_wr_in), .dev_cfg3_in(dev_cfg3_in), .periph_out_in(periph_out_in),
      .pin_out(pin_out), .pin_output_select_out(sel_out), .input_select_out(in_sel),
      .pin_map_lock_out(lock), .config_control_out(cfg_out));

   // ============================================================
   // tasks
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // en stays high for exactly one rising edge
   task automatic map_wr(input logic inp, input logic [2:0] idx, input logic [3:0] d);
      @(negedge clk_in);
      map_wr_in = '{1'b1, inp, idx, d};
      @(negedge clk_in);
      map_wr_in.en = 1'b0;
   endtask : map_wr

   task automatic cfg_wr(input logic unl, input logic lk);
      @(negedge clk_in);
      cfg_wr_in = '{1'b1, unl, {18'h0, lk, 13'h0}};
      @(negedge clk_in);
      cfg_wr_in.en = 1'b0;
   endtask : cfg_wr

   task automatic close_out();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   // ============================================================
   // clock and timeout
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // the whole sequence needs well under 200 cycles
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_fail++;
         close_out();
      end
   end

   // ============================================================
   // sequence
   initial
   begin
      rst_b_in = 1'b0;
      map_wr_in = '0;
      cfg_wr_in = '0;
      dev_cfg3_in = 32'h0;
      // code 0 high proves the null select never reaches a pin
      periph_out_in = 16'h0021;
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      rst_b_in = 1'b1;
      check("reset selects", 32'h0, sel_out);
      check("reset config", 32'h0, cfg_out);
      map_wr(1'b0, 3'h2, 4'h5);
      map_wr(1'b0, 3'h7, 4'h6);
      map_wr(1'b1, 3'h3, 4'h9);
      @(negedge clk_in);
      check("out selects", 32'h60000500, sel_out);
      check("pins", 32'h04, {24'h0, pin_out});
      check("in selects", 32'h00009000, in_sel);
      cfg_wr(1'b0, 1'b1);
      check("lock no key", 32'h0, {31'h0, lock});
      cfg_wr(1'b1, 1'b1);
      check("config locked", 32'h00002000, cfg_out);
      map_wr(1'b0, 3'h2, 4'h3);
      map_wr(1'b1, 3'h3, 4'h1);
      check("locked out", 32'h60000500, sel_out);
      check("locked in", 32'h00009000, in_sel);
      cfg_wr(1'b1, 1'b0);
      check("unlock two way", 32'h0, {31'h0, lock});
      map_wr(1'b0, 3'h2, 4'h3);
      check("reopened", 32'h60000300, sel_out);
      dev_cfg3_in = CFG3_UNPROGRAMMED;
      cfg_wr(1'b1, 1'b1);
      cfg_wr(1'b1, 1'b0);
      check("one way lock", 32'h1, {31'h0, lock});
      map_wr(1'b0, 3'h2, 4'h5);
      check("one way held", 32'h60000300, sel_out);
      rst_b_in = 1'b0;
      @(negedge clk_in);
      rst_b_in = 1'b1;
      check("lock after reset", 32'h0, {31'h0, lock});
      check("selects after reset", 32'h0, sel_out);
      close_out();
   end
endmodule : pin_select_bench
